//--- rtl/beur_pkg.sv
// shared constants and types for the bridge uncorrectable error report block
// assumes a single 100 MHz core clock and an active high asynchronous reset
`default_nettype none
package beur_pkg;
  localparam int NUM_ERR = 3;
  // status bit positions of the three link-side errors
  localparam int ERR_FC_PROTO = 0;
  localparam int ERR_RX_OVFL = 1;
  localparam int ERR_MALF_TLP = 2;
  localparam logic [2:0] STS_RST = 3'h0;
  localparam logic STICKY_RST = 1'h0;
  localparam logic PIN_IDLE_N = 1'h1;
  // completion status codes as carried on the link
  localparam logic [2:0] CPL_SC = 3'h0;
  localparam logic [2:0] CPL_UR = 3'h1;
  localparam logic [2:0] CPL_CA = 3'h4;
  localparam logic [31:0] UR_READ_DATA = 32'hFFFF_FFFF;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    BEUR_RQ_MEM_RD = 2'b00,
    BEUR_RQ_IO_RD = 2'b01,
    BEUR_RQ_IO_WR = 2'b10,
    BEUR_RQ_OTHER = 2'b11
  } beur_req_t;

  typedef enum logic [1:0] {
    BEUR_RSP_NONE = 2'b00,
    BEUR_RSP_NORMAL = 2'b01,
    BEUR_RSP_TGT_ABORT = 2'b10
  } beur_rsp_t;

  // conventional-bus errors to forward, and what goes out on the link
  typedef enum logic [1:0] {
    BEUR_PE_WRITE = 2'b00,
    BEUR_PE_RD_CPL = 2'b01,
    BEUR_PE_CFG_IO_CPL = 2'b10,
    BEUR_PE_SPLIT_MSG = 2'b11
  } beur_perr_t;

  typedef enum logic [1:0] {
    BEUR_FWD_NONE = 2'b00,
    BEUR_FWD_WR_REQ = 2'b01,
    BEUR_FWD_RD_CPL = 2'b10,
    BEUR_FWD_CPL = 2'b11
  } beur_fwd_t;
endpackage
`default_nettype wire

//--- rtl/beur_cfg_if.sv
// reporting enables and per-error qualification between the top and the gate
// assumes the enable, mask and severity members are static config bits held by software
`default_nettype none
interface beur_cfg_if;
  logic serr_en;
  logic dev_fatal_en;
  logic dev_nonfatal_en;
  logic root_sys_fatal_en;
  logic root_sys_nonfatal_en;
  logic rec_fatal_en;
  logic rec_nonfatal_en;
  logic int_disable;
  logic [beur_pkg::NUM_ERR-1:0] mask;
  logic [beur_pkg::NUM_ERR-1:0] fatal_sev;
  logic [beur_pkg::NUM_ERR-1:0] serr_due;
  logic [beur_pkg::NUM_ERR-1:0] int_due;
  logic [beur_pkg::NUM_ERR-1:0] sse_due;

  modport src (
    output serr_en, dev_fatal_en, dev_nonfatal_en, root_sys_fatal_en,
    output root_sys_nonfatal_en, rec_fatal_en, rec_nonfatal_en, int_disable,
    output mask, fatal_sev,
    input serr_due, int_due, sse_due
  );
  modport gate (
    input serr_en, dev_fatal_en, dev_nonfatal_en, root_sys_fatal_en,
    input root_sys_nonfatal_en, rec_fatal_en, rec_nonfatal_en, int_disable,
    input mask, fatal_sev,
    output serr_due, int_due, sse_due
  );
endinterface
`default_nettype wire

//--- rtl/beur_err_gate.sv
// per-error reporting qualification from mask, severity and enables
// assumes the config bits are stable; purely combinational
`default_nettype none
module beur_err_gate #(
  parameter int N = beur_pkg::NUM_ERR
) (
  beur_cfg_if.gate cfg
);
  // severity picks which pair of enables applies
  function automatic logic sev_pick(input logic fatal, input logic f_en, input logic nf_en);
    sev_pick = fatal ? f_en : nf_en;
  endfunction

  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      cfg.serr_due[i] = !cfg.mask[i] && (cfg.serr_en ||
        (sev_pick(cfg.fatal_sev[i], cfg.dev_fatal_en, cfg.dev_nonfatal_en) &&
         sev_pick(cfg.fatal_sev[i], cfg.root_sys_fatal_en, cfg.root_sys_nonfatal_en)));
      cfg.int_due[i] = !cfg.int_disable && !cfg.mask[i] &&
        sev_pick(cfg.fatal_sev[i], cfg.rec_fatal_en, cfg.rec_nonfatal_en) &&
        (cfg.serr_en || sev_pick(cfg.fatal_sev[i], cfg.dev_fatal_en, cfg.dev_nonfatal_en));
      cfg.sse_due[i] = !cfg.mask[i] && cfg.serr_en;
    end
  end
endmodule
`default_nettype wire

//--- rtl/beur_fwd_map.sv
// maps a conventional-bus data error onto the request or completion sent to the link
// assumes one error report per cycle at most; result appears one cycle later
`default_nettype none
module beur_fwd_map (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic perr_vld_i,
  input wire beur_pkg::beur_perr_t perr_kind_i,
  output logic fwd_vld_o,
  output beur_pkg::beur_fwd_t fwd_kind_o,
  output logic fwd_poison_o,
  output logic [2:0] fwd_status_o
);
  beur_pkg::beur_fwd_t kind_nxt;
  logic poison_nxt;
  logic [2:0] status_nxt;

  always_comb
  begin
    kind_nxt = beur_pkg::BEUR_FWD_NONE;
    poison_nxt = 1'h0;
    status_nxt = beur_pkg::CPL_SC;
    case (perr_kind_i)
      beur_pkg::BEUR_PE_WRITE:
      begin
        kind_nxt = beur_pkg::BEUR_FWD_WR_REQ;
        poison_nxt = 1'h1;
      end
      beur_pkg::BEUR_PE_RD_CPL:
      begin
        kind_nxt = beur_pkg::BEUR_FWD_RD_CPL;
        poison_nxt = 1'h1;
      end
      beur_pkg::BEUR_PE_CFG_IO_CPL:
      begin
        kind_nxt = beur_pkg::BEUR_FWD_CPL;
        status_nxt = beur_pkg::CPL_CA;
      end
      default:
      begin
        kind_nxt = beur_pkg::BEUR_FWD_CPL;
        status_nxt = beur_pkg::CPL_CA;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      fwd_vld_o <= 1'h0;
      fwd_kind_o <= beur_pkg::BEUR_FWD_NONE;
      fwd_poison_o <= 1'h0;
      fwd_status_o <= beur_pkg::CPL_SC;
    end
    else
    begin
      fwd_vld_o <= perr_vld_i;
      fwd_kind_o <= perr_vld_i ? kind_nxt : beur_pkg::BEUR_FWD_NONE;
      fwd_poison_o <= perr_vld_i && poison_nxt;
      fwd_status_o <= perr_vld_i ? status_nxt : beur_pkg::CPL_SC;
    end
  end
endmodule
`default_nettype wire

//--- rtl/beur_top.sv
// bridge uncorrectable error report: link error status, SERR#, INTA#/MSI,
// reverse-path error forwarding and UR/CA answers to the conventional bus
// assumes detection strobes are one-cycle pulses synchronous to clk_sys_i
`default_nettype none
module beur_top #(
  parameter int N = beur_pkg::NUM_ERR
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [N-1:0] err_det_i,
  input wire logic [N-1:0] err_mask_i,
  input wire logic [N-1:0] err_fatal_sev_i,
  input wire logic [N-1:0] err_sts_clr_i,
  input wire logic serr_en_i,
  input wire logic dev_fatal_en_i,
  input wire logic dev_nonfatal_en_i,
  input wire logic root_sys_fatal_en_i,
  input wire logic root_sys_nonfatal_en_i,
  input wire logic rec_fatal_en_i,
  input wire logic rec_nonfatal_en_i,
  input wire logic int_disable_i,
  input wire logic msi_en_i,
  input wire logic fatal_det_clr_i,
  input wire logic nonfatal_det_clr_i,
  input wire logic sig_sys_err_clr_i,
  input wire logic int_clr_i,
  input wire logic master_abort_mode_i,
  input wire logic cpl_vld_i,
  input wire logic [2:0] cpl_status_i,
  input wire beur_pkg::beur_req_t cpl_req_i,
  input wire logic [31:0] cpl_data_i,
  input wire logic perr_vld_i,
  input wire beur_pkg::beur_perr_t perr_kind_i,
  output logic [N-1:0] err_sts_o,
  output logic fatal_det_o,
  output logic nonfatal_det_o,
  output logic sig_sys_err_o,
  output logic serr_n_o,
  output logic inta_n_o,
  output logic msi_req_o,
  output logic rsp_vld_o,
  output beur_pkg::beur_rsp_t rsp_kind_o,
  output logic [31:0] rsp_data_o,
  output logic fwd_vld_o,
  output beur_pkg::beur_fwd_t fwd_kind_o,
  output logic fwd_poison_o,
  output logic [2:0] fwd_status_o
);
  beur_cfg_if cfg ();

  logic [N-1:0] err_sts_r;
  logic fatal_det_r;
  logic nonfatal_det_r;
  logic sig_sys_err_r;
  logic serr_n_r;
  logic int_pend_r;
  logic msi_req_r;
  logic rsp_vld_r;
  beur_pkg::beur_rsp_t rsp_kind_r;
  beur_pkg::beur_rsp_t rsp_kind_nxt;
  logic [31:0] rsp_data_r;
  logic [31:0] rsp_data_nxt;
  logic serr_fire;
  logic int_fire;
  logic sse_fire;
  logic fatal_hit;
  logic nonfatal_hit;

  assign cfg.serr_en = serr_en_i;
  assign cfg.dev_fatal_en = dev_fatal_en_i;
  assign cfg.dev_nonfatal_en = dev_nonfatal_en_i;
  assign cfg.root_sys_fatal_en = root_sys_fatal_en_i;
  assign cfg.root_sys_nonfatal_en = root_sys_nonfatal_en_i;
  assign cfg.rec_fatal_en = rec_fatal_en_i;
  assign cfg.rec_nonfatal_en = rec_nonfatal_en_i;
  assign cfg.int_disable = int_disable_i;
  assign cfg.mask = err_mask_i;
  assign cfg.fatal_sev = err_fatal_sev_i;

  beur_err_gate #(
    .N(N)
  ) u_gate (
    .cfg(cfg)
  );

  beur_fwd_map u_fwd (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .perr_vld_i(perr_vld_i),
    .perr_kind_i(perr_kind_i),
    .fwd_vld_o(fwd_vld_o),
    .fwd_kind_o(fwd_kind_o),
    .fwd_poison_o(fwd_poison_o),
    .fwd_status_o(fwd_status_o)
  );

  assign serr_fire = |(err_det_i & cfg.serr_due);
  assign int_fire = |(err_det_i & cfg.int_due);
  assign sse_fire = |(err_det_i & cfg.sse_due);
  assign fatal_hit = |(err_det_i & err_fatal_sev_i);
  assign nonfatal_hit = |(err_det_i & ~err_fatal_sev_i);

  // status bits are sticky; a detection in the clear cycle wins
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      err_sts_r <= beur_pkg::STS_RST;
    else
      err_sts_r <= (err_sts_r & ~err_sts_clr_i) | err_det_i;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      fatal_det_r <= beur_pkg::STICKY_RST;
      nonfatal_det_r <= beur_pkg::STICKY_RST;
    end
    else
    begin
      fatal_det_r <= (fatal_det_r && !fatal_det_clr_i) || fatal_hit;
      nonfatal_det_r <= (nonfatal_det_r && !nonfatal_det_clr_i) || nonfatal_hit;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      sig_sys_err_r <= beur_pkg::STICKY_RST;
    else
      sig_sys_err_r <= (sig_sys_err_r && !sig_sys_err_clr_i) || sse_fire;
  end

  // SERR# is low for one clock after each cycle with a qualifying error
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      serr_n_r <= beur_pkg::PIN_IDLE_N;
    else
      serr_n_r <= !serr_fire;
  end

  // INTA# is level until software acknowledges; MSI is a single request pulse.
  // msi enable is looked at while pending, so a switch mid-way moves the level.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      int_pend_r <= beur_pkg::STICKY_RST;
    else
      int_pend_r <= (int_pend_r && !int_clr_i) || int_fire;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      msi_req_r <= 1'h0;
    else
      msi_req_r <= int_fire && msi_en_i;
  end

  // answer to the conventional-bus requester when the link completion returns
  always_comb
  begin
    rsp_kind_nxt = beur_pkg::BEUR_RSP_NORMAL;
    rsp_data_nxt = cpl_data_i;
    case (cpl_status_i)
      beur_pkg::CPL_UR:
      begin
        if (master_abort_mode_i)
        begin
          rsp_kind_nxt = beur_pkg::BEUR_RSP_TGT_ABORT;
          rsp_data_nxt = beur_pkg::DATA_RST;
        end
        else if (cpl_req_i == beur_pkg::BEUR_RQ_MEM_RD ||
                 cpl_req_i == beur_pkg::BEUR_RQ_IO_RD)
          rsp_data_nxt = beur_pkg::UR_READ_DATA;
        else
          rsp_data_nxt = beur_pkg::DATA_RST;
      end
      beur_pkg::CPL_CA:
      begin
        rsp_kind_nxt = beur_pkg::BEUR_RSP_TGT_ABORT;
        rsp_data_nxt = beur_pkg::DATA_RST;
      end
      default:
      begin
        rsp_kind_nxt = beur_pkg::BEUR_RSP_NORMAL;
        rsp_data_nxt = cpl_data_i;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rsp_vld_r <= 1'h0;
      rsp_kind_r <= beur_pkg::BEUR_RSP_NONE;
      rsp_data_r <= beur_pkg::DATA_RST;
    end
    else
    begin
      rsp_vld_r <= cpl_vld_i;
      rsp_kind_r <= cpl_vld_i ? rsp_kind_nxt : beur_pkg::BEUR_RSP_NONE;
      rsp_data_r <= cpl_vld_i ? rsp_data_nxt : beur_pkg::DATA_RST;
    end
  end

  assign err_sts_o = err_sts_r;
  assign fatal_det_o = fatal_det_r;
  assign nonfatal_det_o = nonfatal_det_r;
  assign sig_sys_err_o = sig_sys_err_r;
  assign serr_n_o = serr_n_r;
  assign inta_n_o = !(int_pend_r && !msi_en_i);
  assign msi_req_o = msi_req_r;
  assign rsp_vld_o = rsp_vld_r;
  assign rsp_kind_o = rsp_kind_r;
  assign rsp_data_o = rsp_data_r;

  fc_sts_set_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    err_det_i[beur_pkg::ERR_FC_PROTO] |=> err_sts_o[beur_pkg::ERR_FC_PROTO])
    else $error("flow control error status not set");

  ovfl_sts_set_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    err_det_i[beur_pkg::ERR_RX_OVFL] |=> err_sts_o[beur_pkg::ERR_RX_OVFL])
    else $error("receiver overflow status not set");

  malf_sts_set_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    err_det_i[beur_pkg::ERR_MALF_TLP] |=> err_sts_o[beur_pkg::ERR_MALF_TLP])
    else $error("malformed TLP status not set");

  malf_sts_hold_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    err_sts_o[beur_pkg::ERR_MALF_TLP] && !err_sts_clr_i[beur_pkg::ERR_MALF_TLP]
    |=> err_sts_o[beur_pkg::ERR_MALF_TLP])
    else $error("malformed TLP status lost without clear");

  serr_masked_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (err_det_i & ~err_mask_i) == '0 |=> serr_n_o)
    else $error("SERR# asserted with all errors masked");

  serr_direct_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (|(err_det_i & ~err_mask_i)) && serr_en_i
    |=> !serr_n_o ##1 (serr_n_o || $past(|(err_det_i & ~err_mask_i))))
    else $error("SERR# not pulsed with SERR enable");

  sev_pick_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    err_det_i[0] && !err_mask_i[0] && !serr_en_i && err_fatal_sev_i[0] && !dev_fatal_en_i
    && err_det_i[2:1] == 2'h0 |=> serr_n_o)
    else $error("fatal error reported without fatal enable");

  int_gate_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    int_disable_i && !int_pend_r |=> !int_pend_r)
    else $error("interrupt raised while disabled");

  msi_path_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    int_fire && msi_en_i |=> msi_req_o && inta_n_o)
    else $error("MSI not sent or INTA# driven with MSI enabled");

  dev_sts_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    nonfatal_hit ##1 !nonfatal_det_clr_i |=> nonfatal_det_o)
    else $error("non-fatal detected bit not held");

  sse_set_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (|(err_det_i & ~err_mask_i)) && serr_en_i |=> sig_sys_err_o)
    else $error("signaled system error not set");

  ur_read_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    cpl_vld_i && cpl_status_i == beur_pkg::CPL_UR && !master_abort_mode_i
    && cpl_req_i != beur_pkg::BEUR_RQ_IO_WR && cpl_req_i != beur_pkg::BEUR_RQ_OTHER
    |=> rsp_vld_o && rsp_kind_o == beur_pkg::BEUR_RSP_NORMAL
    && rsp_data_o == beur_pkg::UR_READ_DATA)
    else $error("UR read did not return all ones");

  ur_abort_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    cpl_vld_i && cpl_status_i == beur_pkg::CPL_UR && master_abort_mode_i
    |=> rsp_kind_o == beur_pkg::BEUR_RSP_TGT_ABORT)
    else $error("UR with master-abort mode set not target abort");

  ca_abort_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    cpl_vld_i && cpl_status_i == beur_pkg::CPL_CA
    |=> rsp_vld_o && rsp_kind_o == beur_pkg::BEUR_RSP_TGT_ABORT)
    else $error("CA completion not answered with target abort");

  poison_fwd_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    perr_vld_i && perr_kind_i == beur_pkg::BEUR_PE_WRITE
    |=> fwd_poison_o && fwd_kind_o == beur_pkg::BEUR_FWD_WR_REQ)
    else $error("parity write not forwarded poisoned");

  ca_fwd_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    perr_vld_i && perr_kind_i == beur_pkg::BEUR_PE_CFG_IO_CPL
    |=> fwd_status_o == beur_pkg::CPL_CA && !fwd_poison_o)
    else $error("cfg/IO completion error not forwarded as CA");
endmodule
`default_nettype wire

//--- verification/beur_link_model.sv
// link partner: answers a forwarded delayed transaction with one completion
// assumes go_i is a one-cycle pulse and only one request is open at a time
`default_nettype none
module beur_link_model (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic go_i,
  input wire logic [3:0] dly_i,
  input wire logic [2:0] sts_i,
  input wire logic [31:0] data_i,
  output logic cpl_vld_o,
  output logic [2:0] cpl_status_o,
  output logic [31:0] cpl_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_r;
  logic [3:0] cnt_r;
  logic [2:0] sts_r;
  logic [31:0] data_r;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      busy_r <= 1'h0;
      cnt_r <= 4'h0;
      sts_r <= 3'h0;
      data_r <= 32'h0;
      cpl_vld_o <= 1'h0;
      cpl_status_o <= 3'h0;
      cpl_data_o <= 32'h0;
    end
    else
    begin
      // outside a completion the fields toggle, so nothing stale can pass
      cpl_vld_o <= 1'h0;
      cpl_status_o <= ~cpl_status_o;
      cpl_data_o <= ~cpl_data_o;
      if (go_i)
      begin
        busy_r <= 1'h1;
        cnt_r <= dly_i;
        sts_r <= sts_i;
        data_r <= data_i;
      end
      else if (busy_r && cnt_r == 4'h0)
      begin
        busy_r <= 1'h0;
        cpl_vld_o <= 1'h1;
        cpl_status_o <= sts_r;
        cpl_data_o <= data_r;
      end
      else if (busy_r)
        cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- verification/beur_top_test.sv
// self-checking bench for the bridge uncorrectable error report block
// assumes a 100 MHz clock; link completions come from beur_link_model
`default_nettype none
module beur_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic [2:0] det = 3'h0;
  logic [2:0] msk = 3'h0;
  logic [2:0] sev = 3'h0;
  // [8] msi [7] int off [6] serr [5:4] dev f/nf [3:2] root f/nf [1:0] rec f/nf
  logic [8:0] cfg = 9'h000;
  logic clr = 1'h0;
  logic mam = 1'h0;
  logic go = 1'h0;
  logic [3:0] dly = 4'h0;
  logic [2:0] sts = 3'h0;
  logic [31:0] cdat = 32'h0;
  beur_pkg::beur_req_t req = beur_pkg::BEUR_RQ_MEM_RD;
  logic perr = 1'h0;
  beur_pkg::beur_perr_t pk = beur_pkg::BEUR_PE_WRITE;
  logic cvld;
  logic [2:0] cst;
  logic [31:0] cdo;
  logic [2:0] ests;
  logic fdet, nfdet, sse, serr_n, inta_n, msi, rvld, fvld, fpois;
  beur_pkg::beur_rsp_t rkind;
  logic [31:0] rdat;
  beur_pkg::beur_fwd_t fkind;
  logic [2:0] fst;
  int num_errors = 0;
  int tests_run = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  beur_link_model u_link (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .go_i(go),
    .dly_i(dly), .sts_i(sts), .data_i(cdat), .cpl_vld_o(cvld), .cpl_status_o(cst),
    .cpl_data_o(cdo));

  beur_top u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .err_det_i(det),
    .err_mask_i(msk), .err_fatal_sev_i(sev), .err_sts_clr_i({3{clr}}),
    .serr_en_i(cfg[6]), .dev_fatal_en_i(cfg[5]), .dev_nonfatal_en_i(cfg[4]),
    .root_sys_fatal_en_i(cfg[3]), .root_sys_nonfatal_en_i(cfg[2]),
    .rec_fatal_en_i(cfg[1]), .rec_nonfatal_en_i(cfg[0]), .int_disable_i(cfg[7]),
    .msi_en_i(cfg[8]), .fatal_det_clr_i(clr), .nonfatal_det_clr_i(clr),
    .sig_sys_err_clr_i(clr), .int_clr_i(clr), .master_abort_mode_i(mam),
    .cpl_vld_i(cvld), .cpl_status_i(cst), .cpl_req_i(req), .cpl_data_i(cdo),
    .perr_vld_i(perr), .perr_kind_i(pk), .err_sts_o(ests), .fatal_det_o(fdet),
    .nonfatal_det_o(nfdet), .sig_sys_err_o(sse), .serr_n_o(serr_n), .inta_n_o(inta_n),
    .msi_req_o(msi), .rsp_vld_o(rvld), .rsp_kind_o(rkind), .rsp_data_o(rdat),
    .fwd_vld_o(fvld), .fwd_kind_o(fkind), .fwd_poison_o(fpois), .fwd_status_o(fst));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic test_errors();
    logic [8:0] tbl [8] = '{9'h040, 9'h028, 9'h014, 9'h022, 9'h043, 9'h143, 9'h1C3, 9'h011};
    logic s, m, se, it;
    for (int c = 0; c < 8; c++)
      for (int k = 0; k < 12; k++)
      begin
        // k[0] severity, k[1] mask, k[3:2] which error
        s = k[0];
        m = k[1];
        se = !m && (tbl[c][6] || (s ? tbl[c][5] && tbl[c][3] : tbl[c][4] && tbl[c][2]));
        it = !tbl[c][7] && !m && (s ? tbl[c][1] : tbl[c][0]);
        it = it && (tbl[c][6] || (s ? tbl[c][5] : tbl[c][4]));
        @(posedge clk_sys_i);
        cfg <= tbl[c];
        sev <= {3{s}};
        msk <= {3{m}};
        det <= 3'h1 << k[3:2];
        @(posedge clk_sys_i);
        det <= 3'h0;
        clr <= 1'h1;
        #1;
        chk("err_sts", 32'(3'h1 << k[3:2]), 32'(ests));
        chk("fatal_det", 32'(s), 32'(fdet));
        chk("nonfatal_det", 32'(!s), 32'(nfdet));
        chk("sig_sys_err", 32'(!m && tbl[c][6]), 32'(sse));
        chk("serr_n", 32'(!se), 32'(serr_n));
        chk("msi_req", 32'(it && tbl[c][8]), 32'(msi));
        chk("inta_n", 32'(!(it && !tbl[c][8])), 32'(inta_n));
        @(posedge clk_sys_i);
        clr <= 1'h0;
        #1;
        chk("serr_n end", 32'h1, 32'(serr_n));
        chk("msi_req end", 32'h0, 32'(msi));
        chk("err_sts clr", 32'h0, 32'({ests, sse, fdet, nfdet, !inta_n}));
      end
    $display("test_errors done");
  endtask

  task automatic test_sticky();
    // status must hold with no clear, and a detection meeting a clear must win
    @(posedge clk_sys_i);
    cfg <= 9'h041;
    sev <= 3'h4;
    msk <= 3'h0;
    det <= 3'h6;
    @(posedge clk_sys_i);
    det <= 3'h0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("sticky sts", 32'h6, 32'(ests));
    chk("sticky det", 32'h3, 32'({fdet, nfdet}));
    chk("sticky sse", 32'h1, 32'(sse));
    chk("sticky inta_n", 32'h0, 32'(inta_n));
    @(posedge clk_sys_i);
    clr <= 1'h1;
    det <= 3'h1;
    @(posedge clk_sys_i);
    clr <= 1'h0;
    det <= 3'h0;
    #1;
    chk("set wins sts", 32'h1, 32'(ests));
    chk("set wins det", 32'h1, 32'({fdet, nfdet}));
    chk("set wins sse", 32'h1, 32'(sse));
    chk("set wins inta_n", 32'h0, 32'(inta_n));
    @(posedge clk_sys_i);
    clr <= 1'h1;
    @(posedge clk_sys_i);
    clr <= 1'h0;
    #1;
    chk("sticky clr", 32'h0, 32'({ests, sse, fdet, nfdet, !inta_n}));
    $display("test_sticky done");
  endtask

  task automatic test_cpl();
    logic [2:0] st [4] = '{beur_pkg::CPL_UR, beur_pkg::CPL_CA, beur_pkg::CPL_SC, 3'h2};
    beur_pkg::beur_rsp_t ek;
    logic [31:0] ed;
    int w;
    for (int k = 0; k < 32; k++)
    begin
      // k[0] mode, k[2:1] request, k[4:3] status; mode flips after launch
      ek = beur_pkg::BEUR_RSP_NORMAL;
      ed = 32'h1234_5600 + 32'(k);
      if (k[4:3] == 2'h1 || (k[4:3] == 2'h0 && k[0]))
      begin
        ek = beur_pkg::BEUR_RSP_TGT_ABORT;
        ed = beur_pkg::DATA_RST;
      end
      else if (k[4:3] == 2'h0)
        ed = (k[2:1] < 2) ? beur_pkg::UR_READ_DATA : beur_pkg::DATA_RST;
      @(posedge clk_sys_i);
      go <= 1'h1;
      sts <= st[k[4:3]];
      req <= beur_pkg::beur_req_t'(k[2:1]);
      mam <= !k[0];
      dly <= {1'h0, k[1], 2'h0};
      cdat <= 32'h1234_5600 + 32'(k);
      @(posedge clk_sys_i);
      go <= 1'h0;
      mam <= k[0];
      w = 0;
      do
      begin
        @(posedge clk_sys_i);
        #1;
        w++;
      end while (rvld !== 1'h1 && w < 20);
      chk("rsp_vld", 32'h1, 32'(rvld));
      if (rvld !== 1'h1)
        break;
      chk("rsp_kind", 32'(ek), 32'(rkind));
      chk("rsp_data", ed, rdat);
      @(posedge clk_sys_i);
      #1;
      chk("rsp_vld end", 32'h0, 32'(rvld));
    end
    $display("test_cpl done");
  endtask

  task automatic test_fwd();
    beur_pkg::beur_fwd_t ek;
    // four errors back to back, each answer checked one cycle behind its request
    for (int k = 0; k < 5; k++)
    begin
      @(posedge clk_sys_i);
      perr <= (k < 4);
      pk <= beur_pkg::beur_perr_t'(k[1:0]);
      #1;
      if (k > 0)
      begin
        ek = (k == 1) ? beur_pkg::BEUR_FWD_WR_REQ :
             (k == 2) ? beur_pkg::BEUR_FWD_RD_CPL : beur_pkg::BEUR_FWD_CPL;
        chk("fwd_vld", 32'h1, 32'(fvld));
        chk("fwd_kind", 32'(ek), 32'(fkind));
        chk("fwd_poison", 32'(k < 3), 32'(fpois));
        chk("fwd_status", 32'(k < 3 ? beur_pkg::CPL_SC : beur_pkg::CPL_CA), 32'(fst));
      end
    end
    @(posedge clk_sys_i);
    #1;
    chk("fwd_vld end", 32'h0, 32'(fvld));
    $display("test_fwd done");
  endtask

  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'h0;
    @(posedge clk_sys_i);
    #1;
    chk("reset idle", 32'h3, 32'({ests, sse, msi, rvld, fvld, serr_n, inta_n}));
    test_errors();
    test_sticky();
    test_cpl();
    test_fwd();
    print_verdict();
  end
endmodule
`default_nettype wire
